// File: common/dsd_consts.svh
// data-space decoder constants: offsets, field positions, reset values
// assumes a 16-bit linear data address and a 16-bit register port
`ifndef DSD_CONSTS_SVH
`define DSD_CONSTS_SVH

`define DSD_ADDR_W        16
`define DSD_DATA_W        16
`define DSD_BUS_DATA_W    32
`define DSD_REG_ADDR_W    4
`define DSD_PAGE_W        8
`define DSD_EVT_W         5

// data-space map
`define DSD_SFR_LAST      16'h07FF
`define DSD_NEAR_LAST     16'h1FFF
`define DSD_RAM_LAST      16'h7FFF
`define DSD_WIN_BIT       15
`define DSD_STACK_BASE    16'h0800
`define DSD_WORD_BYTES    16'h0002

// register offsets
`define DSD_REG_CORE_CTRL 4'h0
`define DSD_REG_WIN_PAGE  4'h1
`define DSD_REG_STK_LIMIT 4'h2
`define DSD_REG_STK_PTR   4'h3
`define DSD_REG_IRQ_STAT  4'h4
`define DSD_REG_IRQ_MASK  4'h5

// fields and reset values
`define DSD_CTRL_WIN_EN   0
`define DSD_LIMIT_RESET   16'hFFFE
`define DSD_EVT_STK_OVF   0
`define DSD_EVT_STK_UNF   1
`define DSD_EVT_WIN_WR    2
`define DSD_EVT_UNMAPPED  3
`define DSD_EVT_MISALIGN  4

`endif

// File: common/dsd_pkg.sv
// types shared by the data-space decoder files
// assumes dsd_consts.svh holds all numeric constants
package dsd_pkg;

  typedef enum logic [1:0] {
    DSD_SZ_BYTE,
    DSD_SZ_WORD,
    DSD_SZ_DWORD
  } dsd_size_t;

  typedef enum logic [1:0] {
    DSD_RT_NONE,
    DSD_RT_SFR,
    DSD_RT_RAM,
    DSD_RT_PM
  } dsd_route_t;

endpackage : dsd_pkg

// File: logic/dsd_stack_guard.sv
// stack pointer with base, upward growth and limit trap
// assumes push and pop come from the core on the same clock, never both at once
`include "dsd_consts.svh"

module dsd_stack_guard (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   en_i,
  // stack operations
  input  wire logic                   push_i,
  input  wire logic                   pop_i,
  input  wire logic                   load_i,
  input  wire logic [`DSD_ADDR_W-1:0] load_val_i,
  input  wire logic [`DSD_ADDR_W-1:0] limit_i,
  // results
  output logic      [`DSD_ADDR_W-1:0] sp_o,
  output logic                        ovf_o,
  output logic                        unf_o
);

  logic [`DSD_ADDR_W-1:0] next_sp;
  logic                   next_ovf;
  logic                   next_unf;
  logic [`DSD_ADDR_W:0]   pushed;

  always_comb begin
    next_sp  = sp_o;
    next_ovf = 1'b0;
    next_unf = 1'b0;
    pushed   = {1'b0, sp_o} + {1'b0, `DSD_WORD_BYTES};
    if (load_i) begin
      next_sp = {load_val_i[`DSD_ADDR_W-1:1], 1'b0};
    end else if (push_i) begin
      // blocked push keeps sp so the trap handler sees the last good value
      if (pushed > {1'b0, limit_i}) begin
        next_ovf = 1'b1; // RULE13
      end else begin
        next_sp = pushed[`DSD_ADDR_W-1:0]; // RULE9
      end
    end else if (pop_i) begin
      if (sp_o <= `DSD_STACK_BASE) begin
        next_unf = 1'b1;
      end else begin
        next_sp = sp_o - `DSD_WORD_BYTES;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_o  <= `DSD_STACK_BASE; // RULE9
      ovf_o <= 1'b0;
      unf_o <= 1'b0;
    end else if (en_i) begin
      sp_o  <= next_sp;
      ovf_o <= next_ovf;
      unf_o <= next_unf;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_push_grows;
    en_i && push_i && !load_i && ({1'b0, sp_o} + 17'h00002 <= {1'b0, limit_i})
      |=> sp_o == $past(sp_o) + 16'h0002 && !ovf_o;
  endproperty
  a_push_grows: assert property (p_push_grows) else $error("push did not advance sp by one word"); // RULE9

  property p_push_trap;
    en_i && push_i && !load_i && ({1'b0, sp_o} + 17'h00002 > {1'b0, limit_i})
      |=> ovf_o && $stable(sp_o);
  endproperty
  a_push_trap: assert property (p_push_trap) else $error("push past limit not trapped"); // RULE13

endmodule : dsd_stack_guard

// File: logic/dsd_decoder.sv
// data-space address decoder: sfr, near, ram, program window, stack limit
// assumes one core access at a time on clk_i and targets that answer two cycles after the request
//
// Contract
// RULE1: the data space is one linear 64 Kbyte byte range with no bank select in the address path.
// RULE2: only the lower 32 Kbytes go to ram; the upper 32 Kbytes are the program window region.
// RULE3: a direct-address access reaches any byte of the lowest 8 Kbytes with no bank selection.
// RULE4: the near region 0000h to 1FFFh holds every sfr and is wholly directly addressable.
// RULE5: addresses 0000h to 07FFh go to the sfr block, not to ram.
// RULE6: with the window on, reads of the upper half return the selected 32 Kbyte program segment, read only.
// RULE7: a page register written by software picks the visible program segment.
// RULE8: one writable bit of core_control turns the window on or off, and software sets it before use.
// RULE9: the stack starts at 0800h and grows upward through the stack pointer register.
// RULE10: a writable stack_limit register holds the address at which the overflow trap is raised.
// RULE11: data is in 2-byte words with byte, word and double-word access sized by the operand.
// RULE12: the window address is the page joined to the low 15 address bits, and window writes are dropped.
// RULE13: a push that would move the stack pointer beyond stack_limit raises the overflow trap.
`include "dsd_consts.svh"

module dsd_decoder #(
  parameter int PAGE_W = `DSD_PAGE_W
) (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        en_i,
  // core data access
  input  wire logic                        acc_req_i,
  input  wire logic                        acc_we_i,
  input  wire logic [`DSD_ADDR_W-1:0]      acc_addr_i,
  input  wire logic [1:0]                  acc_size_i,
  input  wire logic [`DSD_BUS_DATA_W-1:0]  acc_wdata_i,
  output logic      [`DSD_BUS_DATA_W-1:0]  acc_rdata_o,
  output logic                             acc_done_o,
  output logic                             acc_err_o,
  // core stack path
  input  wire logic                        push_i,
  input  wire logic                        pop_i,
  output logic      [`DSD_ADDR_W-1:0]      stack_pointer_working_reg_o,
  output logic                             stack_trap_o,
  // targets
  output logic      [`DSD_ADDR_W-1:0]      tgt_addr_o,
  output logic                             tgt_we_o,
  output logic      [1:0]                  tgt_size_o,
  output logic      [`DSD_BUS_DATA_W-1:0]  tgt_wdata_o,
  output logic                             sfr_sel_o,
  output logic                             ram_sel_o,
  output logic                             pm_rd_o,
  output logic      [PAGE_W+14:0]          pm_addr_o,
  input  wire logic [`DSD_BUS_DATA_W-1:0]  sfr_rdata_i,
  input  wire logic [`DSD_BUS_DATA_W-1:0]  ram_rdata_i,
  input  wire logic [`DSD_BUS_DATA_W-1:0]  pm_rdata_i,
  // register port
  input  wire logic [`DSD_REG_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [`DSD_DATA_W-1:0]      reg_wdata_i,
  input  wire logic                        reg_we_i,
  input  wire logic                        reg_re_i,
  output logic      [`DSD_DATA_W-1:0]      reg_rdata_o,
  // interrupt
  output logic                             irq_o
);

  // software registers
  logic                    program_window_enable;
  logic [PAGE_W-1:0]       program_window_page;
  logic [`DSD_ADDR_W-1:0]  stack_limit;
  logic [`DSD_EVT_W-1:0]   irq_stat;
  logic [`DSD_EVT_W-1:0]   irq_mask;
  logic                    next_window_enable;
  logic [PAGE_W-1:0]       next_page;
  logic [`DSD_ADDR_W-1:0]  next_limit;
  logic [`DSD_EVT_W-1:0]   next_stat;
  logic [`DSD_EVT_W-1:0]   next_mask;
  logic [`DSD_DATA_W-1:0]  next_rdata;
  logic                    next_irq;
  logic                    sp_load;
  logic                    stk_ovf;
  logic                    stk_unf;
  logic [`DSD_EVT_W-1:0]   evt;

  // decode stage
  dsd_pkg::dsd_route_t     route;
  dsd_pkg::dsd_route_t     rt1;
  dsd_pkg::dsd_route_t     rt2;
  dsd_pkg::dsd_route_t     next_rt1;
  dsd_pkg::dsd_route_t     next_rt2;
  logic                    misalign;
  logic                    win_wr;
  logic                    unmapped;
  logic                    act1;
  logic                    act2;
  logic                    next_act1;
  logic                    next_act2;
  logic [PAGE_W+14:0]      next_pm_addr;
  logic [`DSD_BUS_DATA_W-1:0] next_acc_rdata;

  // flat 16-bit address, no bank register anywhere in the path
  always_comb begin
    route    = dsd_pkg::DSD_RT_NONE;
    misalign = 1'b0;
    win_wr   = 1'b0;
    unmapped = 1'b0;
    // word and double word must sit on a 2-byte boundary
    if (acc_size_i != 2'(dsd_pkg::DSD_SZ_BYTE) && acc_addr_i[0]) begin
      misalign = 1'b1; // RULE11
    end else if (acc_addr_i <= `DSD_SFR_LAST) begin
      route = dsd_pkg::DSD_RT_SFR; // RULE5 RULE4 RULE3
    end else if (!acc_addr_i[`DSD_WIN_BIT]) begin
      route = dsd_pkg::DSD_RT_RAM; // RULE2 RULE1
    end else if (acc_we_i) begin
      win_wr = 1'b1; // RULE12
    end else if (program_window_enable) begin
      route = dsd_pkg::DSD_RT_PM; // RULE6 RULE8
    end else begin
      unmapped = 1'b1;
    end
  end

  always_comb begin
    next_act1    = acc_req_i;
    next_rt1     = acc_req_i ? route : dsd_pkg::DSD_RT_NONE;
    next_act2    = act1;
    next_rt2     = rt1;
    next_pm_addr = {program_window_page, acc_addr_i[14:0]}; // RULE12 RULE7
    unique case (rt2)
      dsd_pkg::DSD_RT_SFR: next_acc_rdata = sfr_rdata_i;
      dsd_pkg::DSD_RT_RAM: next_acc_rdata = ram_rdata_i;
      dsd_pkg::DSD_RT_PM:  next_acc_rdata = pm_rdata_i;
      dsd_pkg::DSD_RT_NONE: next_acc_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      act1        <= 1'b0;
      act2        <= 1'b0;
      rt1         <= dsd_pkg::DSD_RT_NONE;
      rt2         <= dsd_pkg::DSD_RT_NONE;
      tgt_addr_o  <= '0;
      tgt_we_o    <= 1'b0;
      tgt_size_o  <= '0;
      tgt_wdata_o <= '0;
      sfr_sel_o   <= 1'b0;
      ram_sel_o   <= 1'b0;
      pm_rd_o     <= 1'b0;
      pm_addr_o   <= '0;
      acc_rdata_o <= '0;
      acc_done_o  <= 1'b0;
      acc_err_o   <= 1'b0;
    end else if (en_i) begin
      act1        <= next_act1;
      act2        <= next_act2;
      rt1         <= next_rt1;
      rt2         <= next_rt2;
      tgt_addr_o  <= acc_addr_i;
      // refused writes (window, misaligned) must never reach a target
      tgt_we_o    <= acc_req_i && acc_we_i && (route == dsd_pkg::DSD_RT_SFR || route == dsd_pkg::DSD_RT_RAM); // RULE12
      tgt_size_o  <= acc_size_i; // RULE11
      tgt_wdata_o <= acc_wdata_i;
      sfr_sel_o   <= acc_req_i && route == dsd_pkg::DSD_RT_SFR;
      ram_sel_o   <= acc_req_i && route == dsd_pkg::DSD_RT_RAM;
      pm_rd_o     <= acc_req_i && route == dsd_pkg::DSD_RT_PM; // RULE6
      pm_addr_o   <= next_pm_addr;
      acc_rdata_o <= next_acc_rdata;
      acc_done_o  <= act2;
      acc_err_o   <= act2 && rt2 == dsd_pkg::DSD_RT_NONE;
    end
  end

  dsd_stack_guard u_stack (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .en_i       (en_i),
    .push_i     (push_i),
    .pop_i      (pop_i),
    .load_i     (sp_load),
    .load_val_i (reg_wdata_i),
    .limit_i    (stack_limit), // RULE10
    .sp_o       (stack_pointer_working_reg_o),
    .ovf_o      (stk_ovf),
    .unf_o      (stk_unf)
  );

  assign sp_load = reg_we_i && reg_addr_i == `DSD_REG_STK_PTR;

  // events are sampled when the access is decoded
  always_comb begin
    evt = '0;
    evt[`DSD_EVT_STK_OVF]  = stk_ovf; // RULE13
    evt[`DSD_EVT_STK_UNF]  = stk_unf;
    evt[`DSD_EVT_WIN_WR]   = acc_req_i && win_wr;
    evt[`DSD_EVT_UNMAPPED] = acc_req_i && unmapped;
    evt[`DSD_EVT_MISALIGN] = acc_req_i && misalign;
  end

  always_comb begin
    next_window_enable = program_window_enable;
    next_page          = program_window_page;
    next_limit         = stack_limit;
    next_mask          = irq_mask;
    next_stat          = irq_stat;
    next_rdata         = '0;
    if (reg_we_i) begin
      unique case (reg_addr_i)
        `DSD_REG_CORE_CTRL: next_window_enable = reg_wdata_i[`DSD_CTRL_WIN_EN]; // RULE8
        `DSD_REG_WIN_PAGE:  next_page = reg_wdata_i[PAGE_W-1:0]; // RULE7
        `DSD_REG_STK_LIMIT: next_limit = {reg_wdata_i[`DSD_ADDR_W-1:1], 1'b0}; // RULE10
        `DSD_REG_IRQ_MASK:  next_mask = reg_wdata_i[`DSD_EVT_W-1:0];
        default:            next_mask = irq_mask;
      endcase
    end
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `DSD_REG_CORE_CTRL: next_rdata[`DSD_CTRL_WIN_EN] = program_window_enable;
        `DSD_REG_WIN_PAGE:  next_rdata[PAGE_W-1:0] = program_window_page;
        `DSD_REG_STK_LIMIT: next_rdata = stack_limit;
        `DSD_REG_STK_PTR:   next_rdata = stack_pointer_working_reg_o;
        `DSD_REG_IRQ_STAT:  next_rdata[`DSD_EVT_W-1:0] = irq_stat;
        `DSD_REG_IRQ_MASK:  next_rdata[`DSD_EVT_W-1:0] = irq_mask;
        default:            next_rdata = '0;
      endcase
      if (reg_addr_i == `DSD_REG_IRQ_STAT) begin
        next_stat = '0;
      end
    end
    // a new event in the clearing cycle survives
    next_stat = next_stat | evt;
    next_irq  = |(next_stat & next_mask);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      program_window_enable <= 1'b0;
      program_window_page   <= '0;
      stack_limit           <= `DSD_LIMIT_RESET;
      irq_stat              <= '0;
      irq_mask              <= '0;
      reg_rdata_o           <= '0;
      irq_o                 <= 1'b0;
      stack_trap_o          <= 1'b0;
    end else if (en_i) begin
      program_window_enable <= next_window_enable;
      program_window_page   <= next_page;
      stack_limit           <= next_limit;
      irq_stat              <= next_stat;
      irq_mask              <= next_mask;
      reg_rdata_o           <= next_rdata;
      irq_o                 <= next_irq;
      stack_trap_o          <= stk_ovf; // RULE13
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_req(logic cond);
    en_i && acc_req_i && cond;
  endsequence

  sequence s_answer;
    en_i [*3] ##1 acc_done_o;
  endsequence

  property p_sfr_route;
    s_req(acc_addr_i <= 16'h07FF && !acc_addr_i[0]) |=> en_i |-> sfr_sel_o && !ram_sel_o;
  endproperty
  a_sfr_route: assert property (p_sfr_route) else $error("low 2K not routed to sfr"); // RULE5

  property p_ram_route;
    s_req(acc_addr_i > 16'h07FF && !acc_addr_i[15] && !acc_addr_i[0]) |=> en_i |-> ram_sel_o && !sfr_sel_o;
  endproperty
  a_ram_route: assert property (p_ram_route) else $error("lower half not routed to ram"); // RULE2

  property p_near_direct;
    s_req(acc_addr_i <= 16'h1FFF && !acc_addr_i[0]) |=> en_i |-> (sfr_sel_o || ram_sel_o) && tgt_addr_o == $past(acc_addr_i);
  endproperty
  a_near_direct: assert property (p_near_direct) else $error("near address not passed straight through"); // RULE3

  property p_win_read;
    s_req(acc_addr_i[15] && !acc_we_i && program_window_enable && !acc_addr_i[0])
      |=> en_i |-> pm_rd_o && pm_addr_o == {program_window_page, tgt_addr_o[14:0]};
  endproperty
  a_win_read: assert property (p_win_read) else $error("window read address wrong"); // RULE12

  property p_win_off;
    s_req(acc_addr_i[15] && !program_window_enable) |=> en_i |-> !pm_rd_o && !ram_sel_o;
  endproperty
  a_win_off: assert property (p_win_off) else $error("window read while disabled"); // RULE8

  property p_win_ro;
    s_req(acc_addr_i[15] && acc_we_i) |=> en_i |-> !tgt_we_o && !pm_rd_o;
  endproperty
  a_win_ro: assert property (p_win_ro) else $error("write reached the window"); // RULE6

  property p_misalign;
    s_req(acc_size_i != 2'b00 && acc_addr_i[0]) ##0 s_answer |-> acc_err_o;
  endproperty
  a_misalign: assert property (p_misalign) else $error("odd word access not refused"); // RULE11

  property p_page_write;
    en_i && reg_we_i && reg_addr_i == 4'h1 |=> program_window_page == $past(reg_wdata_i[PAGE_W-1:0]);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page register did not take write"); // RULE7

  property p_trap_irq;
    en_i && stk_ovf |=> irq_stat[0] && (irq_o || !irq_mask[0]);
  endproperty
  a_trap_irq: assert property (p_trap_irq) else $error("overflow trap lost"); // RULE10

endmodule : dsd_decoder

// File: bench/dsd_target_model.sv
// far-side model: sfr block, data ram and program flash behind the decoder
// assumes one-cycle selects and data sampled in the cycle after the select
module dsd_target_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // requests from the decoder
  input  wire logic [15:0] tgt_addr_i,
  input  wire logic        sfr_sel_i,
  input  wire logic        ram_sel_i,
  input  wire logic        pm_rd_i,
  input  wire logic [22:0] pm_addr_i,
  // read data
  output logic      [31:0] sfr_rdata_o,
  output logic      [31:0] ram_rdata_o,
  output logic      [31:0] pm_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // unselected lanes toggle every cycle so a late or stale sample never matches
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 32'h0;
      ram_rdata_o <= 32'h0;
      pm_rdata_o  <= 32'h0;
    end else begin
      sfr_rdata_o <= sfr_sel_i ? {16'h5F00, tgt_addr_i} : ~sfr_rdata_o;
      ram_rdata_o <= ram_sel_i ? {16'hA000, tgt_addr_i} : ~ram_rdata_o;
      pm_rdata_o  <= pm_rd_i ? {9'h000, pm_addr_i} : ~pm_rdata_o;
    end
  end
endmodule : dsd_target_model

// File: bench/dsd_decoder_tb_top.sv
// self-checking bench for the data-space decoder
// assumes register answers at edge+1 and core access answers at edge+3
`include "dsd_consts.svh"
module dsd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] sz_b = dsd_pkg::DSD_SZ_BYTE;
  localparam logic [1:0] sz_w = dsd_pkg::DSD_SZ_WORD;
  localparam logic [1:0] sz_d = dsd_pkg::DSD_SZ_DWORD;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        en_i = 1'b1;
  logic        acc_req_i = 1'b0;
  logic        acc_we_i = 1'b0;
  logic [15:0] acc_addr_i = 16'h0;
  logic [1:0]  acc_size_i = 2'h0;
  logic [31:0] acc_wdata_i = 32'h0;
  logic [31:0] acc_rdata_o;
  logic        acc_done_o;
  logic        acc_err_o;
  logic        push_i = 1'b0;
  logic        pop_i = 1'b0;
  logic [15:0] stack_pointer_working_reg_o;
  logic        stack_trap_o;
  logic [15:0] tgt_addr_o;
  logic        tgt_we_o;
  logic [1:0]  tgt_size_o;
  logic [31:0] tgt_wdata_o;
  logic        sfr_sel_o;
  logic        ram_sel_o;
  logic        pm_rd_o;
  logic [22:0] pm_addr_o;
  logic [31:0] sfr_rdata_i;
  logic [31:0] ram_rdata_i;
  logic [31:0] pm_rdata_i;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic        irq_o;
  int          mismatches = 0;
  int          cmp_count = 0;

  always #50 clk_i = ~clk_i;

  dsd_decoder dut_u (.clk_i, .rstn_i, .en_i, .acc_req_i, .acc_we_i, .acc_addr_i, .acc_size_i,
    .acc_wdata_i, .acc_rdata_o, .acc_done_o, .acc_err_o, .push_i, .pop_i, .stack_pointer_working_reg_o,
    .stack_trap_o, .tgt_addr_o, .tgt_we_o, .tgt_size_o, .tgt_wdata_o, .sfr_sel_o, .ram_sel_o, .pm_rd_o,
    .pm_addr_o, .sfr_rdata_i, .ram_rdata_i, .pm_rdata_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .irq_o);

  dsd_target_model tgt_u (.clk_i(clk_i), .rstn_i(rstn_i), .tgt_addr_i(tgt_addr_o), .sfr_sel_i(sfr_sel_o),
    .ram_sel_i(ram_sel_o), .pm_rd_i(pm_rd_o), .pm_addr_i(pm_addr_o), .sfr_rdata_o(sfr_rdata_i),
    .ram_rdata_o(ram_rdata_i), .pm_rdata_o(pm_rdata_i));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk(what, 32'(reg_rdata_o), 32'(exp));
  endtask : reg_rd

  // sel is {sfr, ram, pm}; no select means the access must be refused
  task automatic acc(input logic we, input logic [15:0] a, input logic [1:0] sz, input logic [2:0] sel,
                     input logic [31:0] exp);
    int n;
    @(posedge clk_i);
    acc_req_i   <= 1'b1;
    acc_we_i    <= we;
    acc_addr_i  <= a;
    acc_size_i  <= sz;
    acc_wdata_i <= {~a, a};
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    #1;
    chk("select", 32'({sfr_sel_o, ram_sel_o, pm_rd_o}), 32'(sel));
    chk("target we", 32'(tgt_we_o), 32'(we && sel != 3'h0));
    if (sel != 3'h0) begin
      chk("target addr", 32'(tgt_addr_o), 32'(a));
      chk("target size", 32'(tgt_size_o), 32'(sz));
    end
    if (sel == 3'h1) begin
      chk("window addr", 32'(pm_addr_o), exp);
    end
    if (we && sel != 3'h0) begin
      chk("target wdata", tgt_wdata_o, {~a, a});
    end
    n = 0;
    while (acc_done_o !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 4) begin
      mismatches++;
      finish_test();
    end else begin
      chk("done latency", 32'(n), 32'h2);
      chk("access error", 32'(acc_err_o), 32'(sel == 3'h0));
      if (!we) begin
        chk("read data", acc_rdata_o, exp);
      end
    end
  endtask : acc

  task automatic stk(input logic pop, input logic [15:0] sp, input logic trap);
    @(posedge clk_i);
    push_i <= !pop;
    pop_i  <= pop;
    @(posedge clk_i);
    push_i <= 1'b0;
    pop_i  <= 1'b0;
    #1;
    chk("stack pointer", 32'(stack_pointer_working_reg_o), 32'(sp));
    @(posedge clk_i);
    #1;
    chk("stack trap", 32'(stack_trap_o), 32'(trap));
  endtask : stk

  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("sp out", 32'(stack_pointer_working_reg_o), 32'(`DSD_STACK_BASE));
    reg_rd(`DSD_REG_CORE_CTRL, 16'h0000, "control");
    reg_rd(`DSD_REG_WIN_PAGE, 16'h0000, "page");
    reg_rd(`DSD_REG_STK_LIMIT, `DSD_LIMIT_RESET, "limit");
    reg_rd(`DSD_REG_STK_PTR, `DSD_STACK_BASE, "sp reg");
    reg_rd(`DSD_REG_IRQ_MASK, 16'h0000, "mask");
    reg_wr(4'h6, 16'hFFFF);
    reg_rd(4'h6, 16'h0000, "unmapped");
    // map edges, each side of the 07FFh and 7FFFh boundaries, inside edge of 1FFFh
    acc(1'b0, 16'h0000, sz_b, 3'h4, {16'h5F00, 16'h0000});
    acc(1'b0, 16'h07FE, sz_w, 3'h4, {16'h5F00, 16'h07FE});
    acc(1'b0, 16'h0800, sz_w, 3'h2, {16'hA000, 16'h0800});
    acc(1'b0, 16'h1FFE, sz_w, 3'h2, {16'hA000, 16'h1FFE});
    acc(1'b0, 16'h7FFE, sz_w, 3'h2, {16'hA000, 16'h7FFE});
    acc(1'b0, 16'h8000, sz_w, 3'h0, 32'h0);
    reg_wr(`DSD_REG_CORE_CTRL, 16'h0001);
    reg_wr(`DSD_REG_WIN_PAGE, 16'h003C);
    acc(1'b0, 16'h8000, sz_w, 3'h1, {9'h000, 8'h3C, 15'h0000});
    acc(1'b0, 16'hFFFE, sz_w, 3'h1, {9'h000, 8'h3C, 15'h7FFE});
    reg_wr(`DSD_REG_WIN_PAGE, 16'h00C3);
    reg_rd(`DSD_REG_WIN_PAGE, 16'h00C3, "page set");
    reg_rd(`DSD_REG_CORE_CTRL, 16'h0001, "control set");
    acc(1'b0, 16'hC002, sz_d, 3'h1, {9'h000, 8'hC3, 15'h4002});
    acc(1'b1, 16'h8002, sz_w, 3'h0, 32'h0);
    acc(1'b1, 16'h0900, sz_d, 3'h2, 32'h0);
    acc(1'b0, 16'h0801, sz_w, 3'h0, 32'h0);
    acc(1'b0, 16'h0801, sz_b, 3'h2, {16'hA000, 16'h0801});
    reg_rd(`DSD_REG_IRQ_STAT, 16'h001C, "status");
    reg_rd(`DSD_REG_IRQ_STAT, 16'h0000, "status cleared");
    // small limit so the trap comes after three pushes
    // odd limit lands on the word below it
    reg_wr(`DSD_REG_STK_LIMIT, 16'h0807);
    reg_rd(`DSD_REG_STK_LIMIT, 16'h0806, "limit set");
    stk(1'b0, 16'h0802, 1'b0);
    stk(1'b0, 16'h0804, 1'b0);
    stk(1'b0, 16'h0806, 1'b0);
    stk(1'b0, 16'h0806, 1'b1);
    @(posedge clk_i);
    #1;
    chk("irq masked", 32'(irq_o), 32'h0);
    reg_wr(`DSD_REG_IRQ_MASK, 16'h0001);
    @(posedge clk_i);
    #1;
    chk("irq raised", 32'(irq_o), 32'h1);
    reg_rd(`DSD_REG_IRQ_STAT, 16'h0001, "overflow status");
    @(posedge clk_i);
    #1;
    chk("irq cleared", 32'(irq_o), 32'h0);
    // frozen clock enable must swallow the pop
    @(posedge clk_i);
    en_i <= 1'b0;
    stk(1'b1, 16'h0806, 1'b0);
    en_i <= 1'b1;
    stk(1'b1, 16'h0804, 1'b0);
    stk(1'b1, 16'h0802, 1'b0);
    stk(1'b1, 16'h0800, 1'b0);
    stk(1'b1, 16'h0800, 1'b0);
    reg_rd(`DSD_REG_IRQ_STAT, 16'h0002, "underflow status");
    reg_wr(`DSD_REG_STK_PTR, 16'h0A05);
    reg_rd(`DSD_REG_STK_PTR, 16'h0A04, "sp load");
    finish_test();
  end
endmodule : dsd_decoder_tb_top
